//--- logic/dual_serial_port_subsystem.sv
// two asynchronous serial ports behind fixed i/o windows, with per-port enable and fixed irq lines
// assumes synchronous inputs, one 50 MHz clock, and a shared irq wire resolved outside from the enables
//
// Operation
// - port one answers at 3f8h..3ffh, port two at 2f8h..2ffh, never relocated
// - each port has an enable; a disabled port ignores its i/o window
// - port one interrupts only on irq4, port two only on irq3
// - a disabled port releases and stops driving its interrupt line
// - each port holds a sixteen byte character buffer
// - bit rate set by software divisor, reset to about 115.2k baud, up to 3.125M baud at divisor 1
// - character length five to eight bits, stop period one, one and half, two
// - port two drives exactly one line interface, rs-232c or rs-485
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

module serial_port_core
	import serial_sub_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sel,
	input wire io_req_t req,
	output logic [7:0] rdata_r,
	output logic irq_pend,
	output logic tx_active,
	output logic txd_r,
	input wire logic rxd
);
	function automatic logic [3:0] char_bits(input logic [7:0] lcr);
		char_bits = 4'h5 + {2'b00, lcr[1:0]};
	endfunction

	logic [7:0] dll_r, dlm_r, lcr_r, scr_r;
	logic [2:0] ier_r;
	logic fifo_en_r;
	logic [2:0] ofs;
	logic dlab, wr_hit, rd_hit, thr_wr, rbr_rd, txclr, rxclr;
	assign ofs = req.addr[2:0];
	assign dlab = lcr_r[LCR_DLAB];
	assign wr_hit = sel & req.wr;
	assign rd_hit = sel & req.rd;
	assign thr_wr = wr_hit & (ofs == OFS_DATA) & !dlab;
	assign rbr_rd = rd_hit & (ofs == OFS_DATA) & !dlab;
	assign txclr = wr_hit & (ofs == OFS_IIR) & req.wdata[FCR_TXCLR];
	assign rxclr = wr_hit & (ofs == OFS_IIR) & req.wdata[FCR_RXCLR];

	// configuration registers; the divisor shares the data and ier offsets while dlab is set
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dll_r <= DIV_RST[7:0];
			dlm_r <= DIV_RST[15:8];
			lcr_r <= LCR_RST;
			scr_r <= 8'h00;
			ier_r <= 3'h0;
			fifo_en_r <= 1'b0;
		end else if (wr_hit) begin
			case (ofs)
				OFS_DATA: if (dlab) dll_r <= req.wdata;
				OFS_IER: begin
					if (dlab) dlm_r <= req.wdata;
					else ier_r <= req.wdata[2:0];
				end
				OFS_IIR: fifo_en_r <= req.wdata[FCR_EN];
				OFS_LCR: lcr_r <= req.wdata;
				OFS_SCR: scr_r <= req.wdata;
				default: ;
			endcase
		end
	end

	// 16x sampling tick; a zero divisor stops the port rather than running flat out
	logic [15:0] baud_cnt_r, divisor;
	logic tick_r;
	assign divisor = {dlm_r, dll_r};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (divisor == 16'h0000) begin
			baud_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (baud_cnt_r == 16'h0000) begin
			baud_cnt_r <= divisor - 16'h0001;
			tick_r <= 1'b1;
		end else begin
			baud_cnt_r <= baud_cnt_r - 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// transmit character buffer; writes to a full buffer are dropped
	logic [7:0] txf_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] txf_wp_r, txf_rp_r, txf_cnt;
	logic txf_full, txf_empty, sk_push, sk_pop;
	assign txf_cnt = txf_wp_r - txf_rp_r;
	assign txf_full = (txf_cnt == FIFO_DEPTH);
	assign txf_empty = (txf_cnt == 5'h00);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txf_wp_r <= 5'h00;
			txf_rp_r <= 5'h00;
		end else if (txclr) begin
			txf_wp_r <= 5'h00;
			txf_rp_r <= 5'h00;
		end else begin
			if (thr_wr && !txf_full) txf_wp_r <= txf_wp_r + 5'h01;
			if (sk_push) txf_rp_r <= txf_rp_r + 5'h01;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (thr_wr && !txf_full) txf_mem[txf_wp_r[3:0]] <= req.wdata;
	end

	// two-entry buffer between the character buffer and the shifter; the shifter stalls it
	logic [7:0] sk_data_r [2];
	logic [1:0] sk_cnt_r;
	line_state_t tx_st_r;
	assign sk_push = !txf_empty && (sk_cnt_r != 2'h2);
	assign sk_pop = (tx_st_r == ST_IDLE) && (sk_cnt_r != 2'h0);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sk_cnt_r <= 2'h0;
		end else if (txclr) begin
			sk_cnt_r <= 2'h0;
		end else if (sk_push && !sk_pop) begin
			sk_cnt_r <= sk_cnt_r + 2'h1;
		end else if (sk_pop && !sk_push) begin
			sk_cnt_r <= sk_cnt_r - 2'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (sk_push && !sk_pop) begin
			sk_data_r[sk_cnt_r[0]] <= txf_mem[txf_rp_r[3:0]];
		end else if (sk_pop && !sk_push) begin
			sk_data_r[0] <= sk_data_r[1];
		end else if (sk_pop && sk_push) begin
			if (sk_cnt_r == 2'h1) sk_data_r[0] <= txf_mem[txf_rp_r[3:0]];
			else begin
				sk_data_r[0] <= sk_data_r[1];
				sk_data_r[1] <= txf_mem[txf_rp_r[3:0]];
			end
		end
	end

	// transmit shifter, lsb first; stop is 1.5 bits only with five-bit characters
	logic [7:0] tx_sh_r;
	logic [5:0] tx_tk_r, stop_tk;
	logic [2:0] tx_bit_r;
	assign stop_tk = !lcr_r[LCR_STOP] ? TK_BIT : ((lcr_r[1:0] == 2'b00) ? TK_STOP15 : TK_STOP2);
	assign tx_active = (tx_st_r != ST_IDLE);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r <= ST_IDLE;
			tx_sh_r <= 8'h00;
			tx_tk_r <= 6'h00;
			tx_bit_r <= 3'h0;
			txd_r <= 1'b1;
		end else begin
			case (tx_st_r)
				ST_IDLE: begin
					txd_r <= 1'b1;
					tx_tk_r <= 6'h00;
					if (sk_pop) begin
						tx_sh_r <= sk_data_r[0];
						tx_st_r <= ST_START;
					end
				end
				ST_START: begin
					txd_r <= 1'b0;
					if (tick_r) begin
						if (tx_tk_r == TK_BIT - 6'h01) begin
							tx_tk_r <= 6'h00;
							tx_bit_r <= 3'h0;
							tx_st_r <= ST_DATA;
						end else tx_tk_r <= tx_tk_r + 6'h01;
					end
				end
				ST_DATA: begin
					txd_r <= tx_sh_r[0];
					if (tick_r) begin
						if (tx_tk_r == TK_BIT - 6'h01) begin
							tx_tk_r <= 6'h00;
							tx_sh_r <= {1'b0, tx_sh_r[7:1]};
							if ({1'b0, tx_bit_r} == char_bits(lcr_r) - 4'h1) tx_st_r <= ST_STOP;
							else tx_bit_r <= tx_bit_r + 3'h1;
						end else tx_tk_r <= tx_tk_r + 6'h01;
					end
				end
				ST_STOP: begin
					txd_r <= 1'b1;
					if (tick_r) begin
						if (tx_tk_r == stop_tk - 6'h01) tx_st_r <= ST_IDLE;
						else tx_tk_r <= tx_tk_r + 6'h01;
					end
				end
				default: tx_st_r <= ST_IDLE;
			endcase
		end
	end

	// receive shifter; the start bit is rechecked at mid-bit to reject glitches
	line_state_t rx_st_r;
	logic [7:0] rx_sh_r, rx_word;
	logic [5:0] rx_tk_r;
	logic [2:0] rx_bit_r;
	logic rx_done;
	assign rx_done = (rx_st_r == ST_STOP) && tick_r && (rx_tk_r == TK_BIT - 6'h01);
	assign rx_word = rx_sh_r >> (4'h8 - char_bits(lcr_r));
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= ST_IDLE;
			rx_sh_r <= 8'h00;
			rx_tk_r <= 6'h00;
			rx_bit_r <= 3'h0;
		end else begin
			case (rx_st_r)
				ST_IDLE: begin
					rx_tk_r <= 6'h00;
					if (!rxd) rx_st_r <= ST_START;
				end
				ST_START: if (tick_r) begin
					if (rx_tk_r == TK_HALF - 6'h01) begin
						rx_tk_r <= 6'h00;
						rx_bit_r <= 3'h0;
						rx_st_r <= rxd ? ST_IDLE : ST_DATA;
					end else rx_tk_r <= rx_tk_r + 6'h01;
				end
				ST_DATA: if (tick_r) begin
					if (rx_tk_r == TK_BIT - 6'h01) begin
						rx_tk_r <= 6'h00;
						rx_sh_r <= {rxd, rx_sh_r[7:1]};
						if ({1'b0, rx_bit_r} == char_bits(lcr_r) - 4'h1) rx_st_r <= ST_STOP;
						else rx_bit_r <= rx_bit_r + 3'h1;
					end else rx_tk_r <= rx_tk_r + 6'h01;
				end
				ST_STOP: if (tick_r) begin
					if (rx_tk_r == TK_BIT - 6'h01) rx_st_r <= ST_IDLE;
					else rx_tk_r <= rx_tk_r + 6'h01;
				end
				default: rx_st_r <= ST_IDLE;
			endcase
		end
	end

	// receive character buffer; a word arriving when full is lost and flagged
	logic [7:0] rxf_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] rxf_wp_r, rxf_rp_r, rxf_cnt;
	logic rxf_full, rxf_empty, rx_push;
	assign rxf_cnt = rxf_wp_r - rxf_rp_r;
	assign rxf_full = (rxf_cnt == FIFO_DEPTH);
	assign rxf_empty = (rxf_cnt == 5'h00);
	assign rx_push = rx_done && rxd && !rxf_full;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxf_wp_r <= 5'h00;
			rxf_rp_r <= 5'h00;
		end else if (rxclr) begin
			rxf_wp_r <= 5'h00;
			rxf_rp_r <= 5'h00;
		end else begin
			if (rx_push) rxf_wp_r <= rxf_wp_r + 5'h01;
			if (rbr_rd && !rxf_empty) rxf_rp_r <= rxf_rp_r + 5'h01;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rx_push) rxf_mem[rxf_wp_r[3:0]] <= rx_word;
	end

	// sticky line errors, cleared by a status read; a new error in that cycle wins
	logic oe_r, fe_r, thre, temt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_r <= 1'b0;
			fe_r <= 1'b0;
		end else begin
			oe_r <= (rx_done && rxd && rxf_full) || (oe_r && !(rd_hit && ofs == OFS_LSR));
			fe_r <= (rx_done && !rxd) || (fe_r && !(rd_hit && ofs == OFS_LSR));
		end
	end
	assign thre = txf_empty && (sk_cnt_r == 2'h0);
	assign temt = thre && !tx_active;

	// interrupt cause in priority order: line error, received data, transmitter empty
	logic [3:0] iir_code;
	always_comb begin
		if (ier_r[2] && (oe_r || fe_r)) iir_code = IIR_LINE;
		else if (ier_r[0] && !rxf_empty) iir_code = IIR_RXDATA;
		else if (ier_r[1] && thre) iir_code = IIR_THRE;
		else iir_code = IIR_NONE;
	end
	assign irq_pend = !iir_code[0];

	// read data lands one cycle after the strobe and reads zero otherwise
	logic [7:0] rd_val;
	always_comb begin
		case (ofs)
			OFS_DATA: rd_val = dlab ? dll_r : (rxf_empty ? 8'h00 : rxf_mem[rxf_rp_r[3:0]]);
			OFS_IER: rd_val = dlab ? dlm_r : {5'h00, ier_r};
			OFS_IIR: rd_val = {fifo_en_r, fifo_en_r, 2'b00, iir_code};
			OFS_LCR: rd_val = lcr_r;
			OFS_LSR: rd_val = {1'b0, temt, thre, 1'b0, fe_r, 1'b0, oe_r, !rxf_empty};
			OFS_SCR: rd_val = scr_r;
			default: rd_val = 8'h00;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) rdata_r <= 8'h00;
		else rdata_r <= rd_hit ? rd_val : 8'h00;
	end

	sequence s_start_bit;
		(tx_st_r == ST_START) ##1 (txd_r == 1'b0);
	endsequence
	a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_n) (txf_cnt <= FIFO_DEPTH) && (rxf_cnt <= FIFO_DEPTH)) else $error("buffer count above sixteen");
	a_baud_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n) (tick_r && divisor == 16'h0001 && $stable(divisor)) |=> tick_r) else $error("tick spacing wrong");
	a_tx_frame_start: assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(tx_active) |-> s_start_bit) else $error("start bit not driven low");
	a_stop_level: assert property (@(posedge ref_clk) disable iff (!rst_n) (tx_st_r == ST_STOP) |=> txd_r) else $error("stop period not high");
endmodule

module dual_serial_port_subsystem
	import serial_sub_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire io_req_t io_req,
	output logic [7:0] io_rdata,
	output logic io_claim,
	input wire logic [1:0] port_en,
	input wire logic rs485_sel,
	output logic irq4_o,
	output logic irq4_oe,
	output logic irq3_o,
	output logic irq3_oe,
	output logic txd1,
	input wire logic rxd1,
	output logic txd2_232,
	input wire logic rxd2_232,
	output logic rs485_do,
	output logic rs485_de,
	input wire logic rs485_di
);
	function automatic logic in_window(input logic [9:0] addr, input logic [9:0] base);
		in_window = ((addr & WIN_MASK) == base);
	endfunction

	// fixed windows, each gated by its enable so a disabled window is left to the bus
	logic [1:0] hit, pend, active, txd_c;
	logic [7:0] rdata0, rdata1;
	assign hit[0] = port_en[0] && in_window(io_req.addr, COM1_BASE);
	assign hit[1] = port_en[1] && in_window(io_req.addr, COM2_BASE);
	assign io_claim = |hit;
	assign io_rdata = rdata0 | rdata1;

	serial_port_core u_port1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sel(hit[0]),
		.req(io_req),
		.rdata_r(rdata0),
		.irq_pend(pend[0]),
		.tx_active(active[0]),
		.txd_r(txd_c[0]),
		.rxd(rxd1)
	);
	// port two listens only to the selected line interface
	serial_port_core u_port2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sel(hit[1]),
		.req(io_req),
		.rdata_r(rdata1),
		.irq_pend(pend[1]),
		.tx_active(active[1]),
		.txd_r(txd_c[1]),
		.rxd(rs485_sel ? rs485_di : rxd2_232)
	);

	// fixed irq lines; released entirely when the port is off so another card may drive them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq4_o <= 1'b0;
			irq4_oe <= 1'b0;
			irq3_o <= 1'b0;
			irq3_oe <= 1'b0;
		end else begin
			irq4_oe <= port_en[0];
			irq4_o <= port_en[0] && pend[0];
			irq3_oe <= port_en[1];
			irq3_o <= port_en[1] && pend[1];
		end
	end

	// line pins; the unused interface of port two idles high with its driver off
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txd1 <= 1'b1;
			txd2_232 <= 1'b1;
			rs485_do <= 1'b1;
			rs485_de <= 1'b0;
		end else begin
			txd1 <= txd_c[0];
			txd2_232 <= rs485_sel ? 1'b1 : txd_c[1];
			rs485_do <= rs485_sel ? txd_c[1] : 1'b1;
			rs485_de <= rs485_sel && port_en[1] && active[1];
		end
	end

	a_window_decode: assert property (@(posedge ref_clk) disable iff (!rst_n) hit[0] |-> (io_req.addr >= 10'h3f8)) else $error("port one outside its window");
	a_disabled_silent: assert property (@(posedge ref_clk) disable iff (!rst_n) (!port_en[1] && io_req.rd) |=> (rdata1 == 8'h00)) else $error("disabled port answered");
	a_irq_route: assert property (@(posedge ref_clk) disable iff (!rst_n) irq4_o |-> $past(pend[0])) else $error("irq4 without port one cause");
	a_irq_release: assert property (@(posedge ref_clk) disable iff (!rst_n) !port_en[1] |=> !irq3_oe && !irq3_o) else $error("irq3 driven while disabled");
	a_one_iface: assert property (@(posedge ref_clk) disable iff (!rst_n) $stable(rs485_sel) |-> (rs485_sel ? txd2_232 : (rs485_do && !rs485_de))) else $error("both interfaces active");
	a_irq_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) (port_en[0] && pend[0]) [*2] |-> irq4_o && irq4_oe) else $error("pending interrupt not shown");
endmodule

//--- logic/serial_sub_pkg.sv
// constants, field layouts and carrier types shared by the dual serial port subsystem
// assumes a single 50 MHz clock and an 8-bit i/o request port with 10-bit addresses
package serial_sub_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int MAX_BAUD = 115_200;
	localparam int OVERSAMPLE = 16;
	// divisor for the 115.2k rate, loaded at reset; smaller nonzero divisors are accepted and run faster
	localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / (OVERSAMPLE * MAX_BAUD));
	localparam logic [15:0] DIV_RST = DIV_MIN;
	// fixed i/o windows, eight bytes each
	localparam logic [9:0] COM1_BASE = 10'h3f8;
	localparam logic [9:0] COM2_BASE = 10'h2f8;
	localparam logic [9:0] WIN_MASK = 10'h3f8;
	// register offsets inside a window
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IER = 3'h1;
	localparam logic [2:0] OFS_IIR = 3'h2;
	localparam logic [2:0] OFS_LCR = 3'h3;
	localparam logic [2:0] OFS_MCR = 3'h4;
	localparam logic [2:0] OFS_LSR = 3'h5;
	localparam logic [2:0] OFS_MSR = 3'h6;
	localparam logic [2:0] OFS_SCR = 3'h7;
	// line control fields
	localparam int LCR_DLAB = 7;
	localparam int LCR_STOP = 2;
	localparam logic [7:0] LCR_RST = 8'h03;
	// fifo control fields
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	// interrupt identification codes
	localparam logic [3:0] IIR_NONE = 4'h1;
	localparam logic [3:0] IIR_LINE = 4'h6;
	localparam logic [3:0] IIR_RXDATA = 4'h4;
	localparam logic [3:0] IIR_THRE = 4'h2;
	// character buffer
	localparam int PTR_W = 5;
	localparam logic [PTR_W-1:0] FIFO_DEPTH = 5'h10;
	// oversample ticks per bit, per half bit, and for the stop periods
	localparam logic [5:0] TK_BIT = 6'h10;
	localparam logic [5:0] TK_HALF = 6'h08;
	localparam logic [5:0] TK_STOP15 = 6'h18;
	localparam logic [5:0] TK_STOP2 = 6'h20;

	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} io_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_STOP = 2'b11
	} line_state_t;
endpackage

//--- verification/serial_peer.sv
// far-side serial terminal: sends characters and captures framed characters
// assumes the port it faces runs 16 clocks per bit (divisor 1)
`timescale 1ns/1ps

module serial_peer (
	input wire logic ref_clk,
	input wire logic line_in,
	output logic line_out
);
	int cyc = 0;

	// free-running cycle count, used to time frames
	always @(posedge ref_clk) cyc <= cyc + 1;

	initial line_out = 1'b1;

	// start low, data lsb first, one stop high; line idles high (mark)
	task automatic send_char(input logic [7:0] b, input int nb);
		line_out <= 1'b0;
		repeat (16) @(posedge ref_clk);
		for (int i = 0; i < nb; i++) begin
			line_out <= b[i];
			repeat (16) @(posedge ref_clk);
		end
		line_out <= 1'b1;
		repeat (16) @(posedge ref_clk);
	endtask

	// samples mid-bit; ok needs a start within the bound and a high stop
	task automatic take_char(input int nb, output logic [7:0] b, output int t0, output bit ok);
		b = 8'h00;
		ok = 1'b0;
		for (int n = 0; n < 2000 && !ok; n++) begin
			@(posedge ref_clk);
			ok = (line_in === 1'b0);
		end
		t0 = cyc;
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < nb; i++) begin
			repeat (16) @(posedge ref_clk);
			b[i] = line_in;
		end
		repeat (16) @(posedge ref_clk);
		ok = ok && (line_in === 1'b1);
	endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the dual serial port subsystem
// assumes one serial_peer per port line and divisor 1 (16 clocks per bit)
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", nm, (e), (g)); end end

module tb;
	import serial_sub_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	io_req_t io_req = '0;
	logic [1:0] port_en = 2'b11;
	logic rs485_sel = 1'b0;
	logic tog = 1'b0;
	logic [7:0] io_rdata;
	logic io_claim, irq4_o, irq4_oe, irq3_o, irq3_oe, txd1, rxd1, txd2_232, rs485_do, rs485_de, p2_out;
	logic rxd2_232, rs485_di;
	int miscompares = 0;
	int check_count = 0;
	int bad_line = 0;
	int de_cnt = 0;

	always #10 ref_clk = ~ref_clk;
	// the unselected receive line toggles, so listening to it would show
	always @(posedge ref_clk) tog <= ~tog;
	assign rxd2_232 = rs485_sel ? tog : p2_out;
	assign rs485_di = rs485_sel ? p2_out : tog;

	// line watch for the port-two interface that is not selected
	always @(posedge ref_clk) begin
		if (rs485_sel && txd2_232 !== 1'b1) bad_line <= bad_line + 1;
		if (!rs485_sel && (rs485_do !== 1'b1 || rs485_de !== 1'b0)) bad_line <= bad_line + 1;
		if (rs485_de === 1'b1) de_cnt <= de_cnt + 1;
	end

	dual_serial_port_subsystem dut (.ref_clk(ref_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
		.io_claim(io_claim), .port_en(port_en), .rs485_sel(rs485_sel), .irq4_o(irq4_o), .irq4_oe(irq4_oe),
		.irq3_o(irq3_o), .irq3_oe(irq3_oe), .txd1(txd1), .rxd1(rxd1), .txd2_232(txd2_232),
		.rxd2_232(rxd2_232), .rs485_do(rs485_do), .rs485_de(rs485_de), .rs485_di(rs485_di));
	serial_peer p1 (.ref_clk(ref_clk), .line_in(txd1), .line_out(rxd1));
	serial_peer p2 (.ref_clk(ref_clk), .line_in(rs485_sel ? rs485_do : txd2_232), .line_out(p2_out));

	task automatic report_and_stop();
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		io_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		io_req <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		io_req <= '0;
		#1 v = io_rdata;
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e, input string nm);
		logic [7:0] v;
		rd(a, v);
		`CHK(nm, e, v)
	endtask

	// polls the data-ready flag; a bound, not a fixed wait
	task automatic wait_dr(input logic [9:0] b);
		logic [7:0] v;
		v = 8'h00;
		for (int n = 0; n < 300 && v[0] !== 1'b1; n++) rd({b[9:3], OFS_LSR}, v);
		if (v[0] !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	// divisor 1 keeps frames short; buffers enabled and cleared
	task automatic cfg(input logic [9:0] b, input logic [7:0] lcr);
		wr({b[9:3], OFS_LCR}, 8'h80);
		wr({b[9:3], OFS_DATA}, 8'h01);
		wr({b[9:3], OFS_IER}, 8'h00);
		wr({b[9:3], OFS_LCR}, lcr);
		wr({b[9:3], OFS_IIR}, 8'h07);
	endtask

	task automatic t_reset();
		// let the first edge after release settle before looking
		#1;
		`CHK("irq4 off", 1'b0, irq4_o)
		`CHK("oe4 on", 1'b1, irq4_oe)
		rd_chk(10'h3fd, 8'h60, "lsr1");
		rd_chk(10'h2fb, LCR_RST, "lcr2");
		wr(10'h3fb, 8'h83);
		rd_chk(10'h3f8, DIV_RST[7:0], "div lo");
		rd_chk(10'h3f9, DIV_RST[15:8], "div hi");
	endtask

	task automatic t_decode();
		logic [9:0] a[6] = '{10'h3f8, 10'h3ff, 10'h2f8, 10'h2ff, 10'h2f7, 10'h0f8};
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			io_req.addr <= a[i];
			@(posedge ref_clk);
			`CHK("claim", i < 4, io_claim)
		end
		wr(10'h3ff, 8'ha5);
		wr(10'h2ff, 8'h5a);
		@(posedge ref_clk);
		port_en <= 2'b10;
		wr(10'h3ff, 8'h11);
		`CHK("claim off", 1'b0, io_claim)
		rd_chk(10'h3ff, 8'h00, "off read");
		rd_chk(10'h2ff, 8'h5a, "scratch2");
		@(posedge ref_clk);
		port_en <= 2'b11;
		rd_chk(10'h3ff, 8'ha5, "scratch1");
		// port two off: its window reads zero and its irq line is let go
		@(posedge ref_clk);
		port_en <= 2'b01;
		rd_chk(10'h2ff, 8'h00, "off read2");
		`CHK("oe3 released", 1'b0, irq3_oe)
		`CHK("irq3 off", 1'b0, irq3_o)
		@(posedge ref_clk);
		port_en <= 2'b11;
		rd_chk(10'h2ff, 8'h5a, "scratch2 back");
	endtask

	// back-to-back characters: the start-to-start gap is the whole frame
	task automatic t_tx();
		logic [7:0] lcr[4] = '{8'h03, 8'h04, 8'h05, 8'h02};
		int len[4] = '{160, 120, 144, 144};
		logic [7:0] b0, b1, m;
		int t0, t1, nb;
		bit ok0, ok1;
		for (int k = 0; k < 4; k++) begin
			cfg(10'h3f8, lcr[k]);
			nb = 5 + int'(lcr[k][1:0]);
			m = 8'hff >> (8 - nb);
			fork
				begin
					p1.take_char(nb, b0, t0, ok0);
					p1.take_char(nb, b1, t1, ok1);
				end
				begin
					wr(10'h3f8, 8'ha5);
					wr(10'h3f8, 8'h3c);
				end
			join
			`CHK("tx frame", 2'b11, {ok0, ok1})
			`CHK("tx char0", 8'ha5 & m, b0)
			`CHK("tx char1", 8'h3c & m, b1)
			`CHK("tx length", 1'b1, t1 - t0 >= len[k] && t1 - t0 <= len[k] + 3)
			repeat (40) @(posedge ref_clk);
		end
	endtask

	// seventeen characters into a sixteen-deep buffer: last one overruns
	task automatic t_rx();
		cfg(10'h3f8, 8'h03);
		for (int i = 0; i < 17; i++) p1.send_char(8'h30 + 8'(i), 8);
		rd_chk(10'h3fd, 8'h63, "lsr overrun");
		for (int i = 0; i < 16; i++) rd_chk(10'h3f8, 8'h30 + 8'(i), "rx char");
		rd_chk(10'h3fd, 8'h60, "lsr empty");
	endtask

	task automatic t_irq();
		wr(10'h3f9, 8'h02);
		repeat (3) @(posedge ref_clk);
		`CHK("irq4 thre", 1'b1, irq4_o)
		`CHK("irq3 quiet", 1'b0, irq3_o)
		rd_chk(10'h3fa, {2'b11, 2'b00, IIR_THRE}, "iir1");
		@(posedge ref_clk);
		port_en <= 2'b10;
		repeat (2) @(posedge ref_clk);
		`CHK("oe4 released", 1'b0, irq4_oe)
		`CHK("irq4 disabled", 1'b0, irq4_o)
		port_en <= 2'b11;
		repeat (2) @(posedge ref_clk);
		`CHK("irq4 back", 1'b1, irq4_o)
		wr(10'h3f9, 8'h00);
		wr(10'h2f9, 8'h02);
		repeat (3) @(posedge ref_clk);
		`CHK("irq4 masked", 1'b0, irq4_o)
		`CHK("irq3 thre", 1'b1, irq3_o)
		`CHK("oe3 on", 1'b1, irq3_oe)
		wr(10'h2f9, 8'h00);
	endtask

	// port two on each interface in turn, the other one must stay idle
	task automatic t_link2(input logic sel, input logic [7:0] tx, input logic [7:0] rx);
		logic [7:0] b;
		int t, s0, d0;
		bit ok;
		@(posedge ref_clk);
		rs485_sel <= sel;
		cfg(10'h2f8, 8'h03);
		s0 = bad_line;
		d0 = de_cnt;
		fork
			p2.take_char(8, b, t, ok);
			wr(10'h2f8, tx);
		join
		repeat (20) @(posedge ref_clk);
		`CHK("link2 tx", tx, b)
		`CHK("other idle", 0, bad_line - s0)
		`CHK("de frame", sel, de_cnt - d0 >= 150 && de_cnt - d0 <= 170)
		`CHK("de off", 1'b0, rs485_de)
		p2.send_char(rx, 8);
		wait_dr(10'h2f8);
		rd_chk(10'h2f8, rx, "link2 rx");
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		`CHK("rst rdata", 8'h00, io_rdata)
		`CHK("rst oe4", 1'b0, irq4_oe)
		`CHK("rst irq3", 1'b0, irq3_o)
		`CHK("rst txd1", 1'b1, txd1)
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_decode();
		t_tx();
		t_rx();
		t_irq();
		t_link2(1'b1, 8'h96, 8'h69);
		t_link2(1'b0, 8'h3c, 8'h42);
		report_and_stop();
	end
endmodule
